/* File: verilog/fseq_pkg.sv */
package fseq_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int WINDOW_US = 100;
	localparam int WINDOW_CYC = WINDOW_US * CYC_PER_US;
	localparam int RESET_US = 25;
	localparam int RESET_CYC = RESET_US * CYC_PER_US;
	localparam int SUSP_NS = 1000;
	localparam int SUSP_CYC = (SUSP_NS * CYC_PER_US + 999) / 1000;
	localparam int CNT_W = 10;

	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_RADDR = 8'h04;
	localparam logic [7:0] OFF_RDATA = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam int AW = 12;
	localparam int SW = 12;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_SEL_LSB = 20;
	localparam int RADDR_SEL_LSB = 12;

	localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
	localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
	localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
	localparam logic [11:0] ADDR_UNLOCK2 = 12'haaa;
	localparam logic [7:0] CODE_BYPASS = 8'h20;
	localparam logic [7:0] CODE_PROGRAM = 8'ha0;
	localparam logic [7:0] CODE_ERASE = 8'h80;
	localparam logic [7:0] CODE_BULK = 8'h10;
	localparam logic [7:0] CODE_SECTOR = 8'h30;
	localparam logic [7:0] CODE_RESUME = 8'h30;
	localparam logic [7:0] CODE_SUSPEND = 8'hb0;
	localparam logic [7:0] CODE_BYP_EXIT1 = 8'h90;
	localparam logic [7:0] CODE_BYP_EXIT2 = 8'h00;
	localparam logic [7:0] CODE_RESET = 8'hf0;
	localparam logic [7:0] PREPROG_BYTE = 8'h00;
	localparam logic [7:0] INVALID_BYTE = 8'h00;

	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int ERROR_BIT = 5;
	localparam int WINDOW_BIT = 3;

	typedef enum logic [4:0] {
		S_READ = 5'h00, S_UNLK1 = 5'h01, S_UNLK2 = 5'h02, S_PROG_ARG = 5'h03,
		S_ERS3 = 5'h04, S_ERS4 = 5'h05, S_ERS5 = 5'h06, S_BYP = 5'h07,
		S_BYP_PROG = 5'h08, S_BYP_EXIT = 5'h09, S_PROG_CHK = 5'h0a, S_PROG = 5'h0b,
		S_BULK_PRE = 5'h0c, S_BULK_ERS = 5'h0d, S_WINDOW = 5'h0e, S_SECT_ERS = 5'h0f,
		S_SUSPENDING = 5'h10, S_SUSPENDED = 5'h11, S_ERROR = 5'h12, S_RST_WAIT = 5'h13
	} state_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0, OP_PROGRAM = 3'h1, OP_FILL = 3'h2, OP_ERASE = 3'h3,
		OP_SUSPEND = 3'h4, OP_RESUME = 3'h5, OP_ABORT = 3'h6
	} op_t;

	typedef struct packed {
		logic req;
		op_t op;
		logic [AW-1:0] waddr;
		logic [7:0] wdata;
		logic [SW-1:0] wsel;
		logic [AW-1:0] raddr;
		logic [SW-1:0] rsel;
	} arr_req_t;

	typedef struct packed {
		logic done;
		logic fail;
		logic [7:0] rdata;
	} arr_rsp_t;

	typedef struct packed {
		state_t st;
		logic bypass;
		logic erase_op;
		logic started;
		logic err;
		logic toggle;
		logic [CNT_W-1:0] cnt;
		logic [AW-1:0] tgt_addr;
		logic [7:0] tgt_data;
		logic [SW-1:0] tgt_sel;
		logic [SW-1:0] ers_sel;
		logic [AW-1:0] raddr;
		logic [SW-1:0] rsel;
		logic dph_wr;
		logic [7:0] dph_addr;
		logic [31:0] hrdata;
		arr_req_t arr;
	} seq_state_t;

	localparam seq_state_t SEQ_RESET = '0;
endpackage

/* File: verilog/flash_program_erase_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_sequencer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output var logic hreadyout,
	output var logic hresp,
	output var logic [31:0] hrdata,
	input wire logic [11:0] sector_protect,
	output var fseq_pkg::arr_req_t flash_cmd,
	input wire fseq_pkg::arr_rsp_t flash_rsp,
	output var logic ready_busy_pin
);
	fseq_pkg::seq_state_t s;
	fseq_pkg::seq_state_t n;
	logic acc;
	logic cmd_ev;
	logic [7:0] wd;
	logic [11:0] wa;
	logic [11:0] wsl;
	logic [11:0] live;
	logic unl1;
	logic unl2;
	logic prog_hit;
	logic ers_hit;
	logic show;
	logic rd_stat;
	logic [7:0] stat;
	logic [7:0] rbyte;

	function automatic logic any_hit(input logic [11:0] a, input logic [11:0] b);
		return |(a & b);
	endfunction

	// hsize is not decoded: only whole-word singles are expected
	assign acc = hsel && htrans[1] && hready;
	assign cmd_ev = s.dph_wr && (s.dph_addr == fseq_pkg::OFF_CMD);
	assign wd = hwdata[7:0];
	assign wa = hwdata[fseq_pkg::CMD_ADDR_LSB +: fseq_pkg::AW];
	assign wsl = hwdata[fseq_pkg::CMD_SEL_LSB +: fseq_pkg::SW];
	assign live = wsl & ~sector_protect;
	assign unl1 = (wd == fseq_pkg::CODE_UNLOCK1) && (wa == fseq_pkg::ADDR_UNLOCK1);
	assign unl2 = (wd == fseq_pkg::CODE_UNLOCK2) && (wa == fseq_pkg::ADDR_UNLOCK2);

	assign prog_hit = (s.raddr == s.tgt_addr) && any_hit(s.rsel, s.tgt_sel);
	assign ers_hit = any_hit(s.rsel, s.ers_sel);

	// status only answers at the monitored location while an algorithm owns it
	always_comb begin
		unique case (s.st)
			fseq_pkg::S_PROG_CHK, fseq_pkg::S_PROG: show = prog_hit;
			fseq_pkg::S_BULK_PRE, fseq_pkg::S_BULK_ERS, fseq_pkg::S_WINDOW,
			fseq_pkg::S_SECT_ERS, fseq_pkg::S_SUSPENDING: show = ers_hit;
			fseq_pkg::S_ERROR: show = s.erase_op ? ers_hit : prog_hit;
			default: show = 1'b0;
		endcase
	end

	always_comb begin
		stat = 8'h00;
		stat[fseq_pkg::POLL_BIT] = s.erase_op ? 1'b0 : ~s.tgt_data[7];
		stat[fseq_pkg::TOGGLE_BIT] = s.toggle;
		stat[fseq_pkg::ERROR_BIT] = s.err;
		stat[fseq_pkg::WINDOW_BIT] = s.erase_op && (s.st != fseq_pkg::S_WINDOW);
	end

	// suspended erase sector has no defined contents
	assign rbyte = show ? stat :
		((s.st == fseq_pkg::S_SUSPENDED) && ers_hit) ? fseq_pkg::INVALID_BYTE :
		flash_rsp.rdata;
	assign rd_stat = acc && !hwrite && (haddr[7:0] == fseq_pkg::OFF_RDATA) && show;

	always_comb begin
		unique case (s.st)
			fseq_pkg::S_PROG_CHK, fseq_pkg::S_PROG, fseq_pkg::S_BULK_PRE,
			fseq_pkg::S_BULK_ERS, fseq_pkg::S_WINDOW, fseq_pkg::S_SECT_ERS,
			fseq_pkg::S_SUSPENDING, fseq_pkg::S_ERROR,
			fseq_pkg::S_RST_WAIT: ready_busy_pin = 1'b0;
			default: ready_busy_pin = 1'b1;
		endcase
	end

	// one wait state while the target byte is checked, so reads never see its address
	assign hreadyout = (s.st != fseq_pkg::S_PROG_CHK);
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign flash_cmd = s.arr;

	always_comb begin
		n = s;
		n.arr.req = 1'b0;
		n.arr.op = fseq_pkg::OP_NONE;
		n.dph_wr = acc && hwrite;
		n.dph_addr = haddr[7:0];
		if (s.dph_wr && (s.dph_addr == fseq_pkg::OFF_RADDR)) begin
			n.raddr = hwdata[fseq_pkg::AW-1:0];
			n.rsel = hwdata[fseq_pkg::RADDR_SEL_LSB +: fseq_pkg::SW];
		end
		if (acc && !hwrite) begin
			unique case (haddr[7:0])
				fseq_pkg::OFF_RADDR: n.hrdata = {8'h00, s.rsel, s.raddr};
				fseq_pkg::OFF_RDATA: begin
					n.hrdata = {24'h000000, rbyte};
					if (show) n.toggle = ~s.toggle;
				end
				fseq_pkg::OFF_STAT: n.hrdata = {24'h000000, ready_busy_pin, s.err, s.bypass, s.st};
				default: n.hrdata = 32'h00000000;
			endcase
		end
		unique case (s.st)
			fseq_pkg::S_READ: begin
				if (cmd_ev && unl1) n.st = fseq_pkg::S_UNLK1;
			end
			fseq_pkg::S_UNLK1: begin
				if (cmd_ev) n.st = unl2 ? fseq_pkg::S_UNLK2 : fseq_pkg::S_READ;
			end
			fseq_pkg::S_UNLK2: begin
				if (cmd_ev) begin
					n.st = fseq_pkg::S_READ;
					if (wa == fseq_pkg::ADDR_UNLOCK1) begin
						if (wd == fseq_pkg::CODE_PROGRAM) begin
							n.st = fseq_pkg::S_PROG_ARG;
						end else if (wd == fseq_pkg::CODE_BYPASS) begin
							n.st = fseq_pkg::S_BYP;
							n.bypass = 1'b1;
						end else if (wd == fseq_pkg::CODE_ERASE) begin
							n.st = fseq_pkg::S_ERS3;
						end
					end
				end
			end
			fseq_pkg::S_ERS3: begin
				if (cmd_ev) n.st = unl1 ? fseq_pkg::S_ERS4 : fseq_pkg::S_READ;
			end
			fseq_pkg::S_ERS4: begin
				if (cmd_ev) n.st = unl2 ? fseq_pkg::S_ERS5 : fseq_pkg::S_READ;
			end
			fseq_pkg::S_ERS5: begin
				if (cmd_ev) begin
					n.st = fseq_pkg::S_READ;
					n.erase_op = 1'b1;
					n.err = 1'b0;
					if ((wd == fseq_pkg::CODE_BULK) && (wa == fseq_pkg::ADDR_UNLOCK1)) begin
						// zeros first so every cell erases from the same level
						n.st = fseq_pkg::S_BULK_PRE;
						n.ers_sel = 12'hfff;
						n.arr.req = 1'b1;
						n.arr.op = fseq_pkg::OP_FILL;
						n.arr.wdata = fseq_pkg::PREPROG_BYTE;
						n.arr.wsel = ~sector_protect;
					end else if ((wd == fseq_pkg::CODE_SECTOR) && (|live)) begin
						n.st = fseq_pkg::S_WINDOW;
						n.ers_sel = live;
						n.cnt = '0;
						n.started = 1'b0;
					end
				end
			end
			fseq_pkg::S_PROG_ARG, fseq_pkg::S_BYP_PROG: begin
				if (cmd_ev) begin
					n.st = s.bypass ? fseq_pkg::S_BYP : fseq_pkg::S_READ;
					if (!any_hit(wsl, sector_protect)) begin
						n.st = fseq_pkg::S_PROG_CHK;
						n.tgt_addr = wa;
						n.tgt_data = wd;
						n.tgt_sel = wsl;
						n.erase_op = 1'b0;
						n.err = 1'b0;
					end
				end
			end
			fseq_pkg::S_PROG_CHK: begin
				if (|(s.tgt_data & ~flash_rsp.rdata)) begin
					n.st = fseq_pkg::S_ERROR;
					n.err = 1'b1;
				end else begin
					n.st = fseq_pkg::S_PROG;
					n.arr.req = 1'b1;
					n.arr.op = fseq_pkg::OP_PROGRAM;
					n.arr.waddr = s.tgt_addr;
					n.arr.wdata = s.tgt_data;
					n.arr.wsel = s.tgt_sel;
				end
			end
			fseq_pkg::S_PROG: begin
				if (flash_rsp.fail) begin
					n.st = fseq_pkg::S_ERROR;
					n.err = 1'b1;
				end else if (flash_rsp.done) begin
					n.st = s.bypass ? fseq_pkg::S_BYP : fseq_pkg::S_READ;
				end
			end
			fseq_pkg::S_BYP: begin
				if (cmd_ev && (wd == fseq_pkg::CODE_PROGRAM)) n.st = fseq_pkg::S_BYP_PROG;
				else if (cmd_ev && (wd == fseq_pkg::CODE_BYP_EXIT1)) n.st = fseq_pkg::S_BYP_EXIT;
			end
			fseq_pkg::S_BYP_EXIT: begin
				if (cmd_ev) begin
					n.st = fseq_pkg::S_BYP;
					if (wd == fseq_pkg::CODE_BYP_EXIT2) begin
						n.st = fseq_pkg::S_READ;
						n.bypass = 1'b0;
					end
				end
			end
			fseq_pkg::S_BULK_PRE: begin
				if (flash_rsp.fail) begin
					n.st = fseq_pkg::S_ERROR;
					n.err = 1'b1;
				end else if (flash_rsp.done) begin
					n.st = fseq_pkg::S_BULK_ERS;
					n.arr.req = 1'b1;
					n.arr.op = fseq_pkg::OP_ERASE;
					n.arr.wsel = ~sector_protect;
				end
			end
			fseq_pkg::S_BULK_ERS: begin
				// command writes are not looked at here at all; RADDR writes still take effect
				if (flash_rsp.fail) begin
					n.st = fseq_pkg::S_ERROR;
					n.err = 1'b1;
				end else if (flash_rsp.done) begin
					n.st = fseq_pkg::S_READ;
				end
			end
			fseq_pkg::S_WINDOW: begin
				n.cnt = s.cnt + 1'b1;
				if (cmd_ev) begin
					if ((wd == fseq_pkg::CODE_SECTOR) && (|wsl)) begin
						n.ers_sel = s.ers_sel | live;
						n.cnt = '0;
					end else if ((wd == fseq_pkg::CODE_SUSPEND) && (|wsl)) begin
						n.st = fseq_pkg::S_SUSPENDING;
						n.cnt = '0;
					end else begin
						n.st = fseq_pkg::S_READ;
					end
				end else if (s.cnt == fseq_pkg::CNT_W'(fseq_pkg::WINDOW_CYC - 1)) begin
					n.st = fseq_pkg::S_SECT_ERS;
					n.started = 1'b1;
					n.arr.req = 1'b1;
					n.arr.op = fseq_pkg::OP_ERASE;
					n.arr.wsel = s.ers_sel;
				end
			end
			fseq_pkg::S_SECT_ERS: begin
				if (flash_rsp.fail) begin
					n.st = fseq_pkg::S_ERROR;
					n.err = 1'b1;
				end else if (flash_rsp.done) begin
					n.st = fseq_pkg::S_READ;
				end else if (cmd_ev && (wd == fseq_pkg::CODE_RESET)) begin
					n.st = fseq_pkg::S_RST_WAIT;
					n.cnt = '0;
					n.arr.req = 1'b1;
					n.arr.op = fseq_pkg::OP_ABORT;
				end else if (cmd_ev && (wd == fseq_pkg::CODE_SUSPEND) && (|wsl)) begin
					n.st = fseq_pkg::S_SUSPENDING;
					n.cnt = '0;
					n.arr.req = 1'b1;
					n.arr.op = fseq_pkg::OP_SUSPEND;
				end
			end
			fseq_pkg::S_SUSPENDING: begin
				n.cnt = s.cnt + 1'b1;
				if (flash_rsp.done) n.st = fseq_pkg::S_READ;
				else if (s.cnt == fseq_pkg::CNT_W'(fseq_pkg::SUSP_CYC - 1)) n.st = fseq_pkg::S_SUSPENDED;
			end
			fseq_pkg::S_SUSPENDED: begin
				if (cmd_ev && (wd == fseq_pkg::CODE_RESUME) && (|wsl)) begin
					n.st = fseq_pkg::S_SECT_ERS;
					n.started = 1'b1;
					n.arr.req = 1'b1;
					n.arr.op = s.started ? fseq_pkg::OP_RESUME : fseq_pkg::OP_ERASE;
					n.arr.wsel = s.ers_sel;
				end else if (cmd_ev && (wd == fseq_pkg::CODE_RESET)) begin
					// abort reaches the array only if the erase had started; the array keeps no state for it
					n.st = fseq_pkg::S_READ;
					n.arr.req = s.started;
					n.arr.op = s.started ? fseq_pkg::OP_ABORT : fseq_pkg::OP_NONE;
				end
			end
			fseq_pkg::S_ERROR: begin
				if (cmd_ev && (wd == fseq_pkg::CODE_RESET)) begin
					n.st = fseq_pkg::S_RST_WAIT;
					n.cnt = '0;
				end
			end
			fseq_pkg::S_RST_WAIT: begin
				n.cnt = s.cnt + 1'b1;
				if (s.cnt == fseq_pkg::CNT_W'(fseq_pkg::RESET_CYC - 1)) begin
					n.st = fseq_pkg::S_READ;
					n.err = 1'b0;
				end
			end
			default: n.st = fseq_pkg::S_READ;
		endcase
		n.arr.raddr = (n.st == fseq_pkg::S_PROG_CHK) ? n.tgt_addr : n.raddr;
		n.arr.rsel = (n.st == fseq_pkg::S_PROG_CHK) ? n.tgt_sel : n.rsel;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) s <= fseq_pkg::SEQ_RESET;
		else s <= n;
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	AST_PROG_NO_RAISE: assert property ((s.arr.req && s.arr.op == fseq_pkg::OP_PROGRAM) |->
		($past(s.st) == fseq_pkg::S_PROG_CHK) && ((s.arr.wdata & ~$past(flash_rsp.rdata)) == 8'h00))
		else $error("program issued that would raise a bit");
	AST_RAISE_ERR: assert property ((s.st == fseq_pkg::S_PROG_CHK && |(s.tgt_data & ~flash_rsp.rdata)) |=>
		(s.st == fseq_pkg::S_ERROR && s.err && !s.arr.req))
		else $error("zero to one write did not flag error");
	AST_POLL_INV: assert property ((rd_stat && s.st == fseq_pkg::S_PROG) |=>
		(hrdata[7] != s.tgt_data[7]))
		else $error("poll bit not inverted during program");
	AST_TOGGLE: assert property ((rd_stat ##2 rd_stat) |=>
		(hrdata[6] != $past(hrdata[6], 2)))
		else $error("toggle bit did not flip");
	AST_ERASE_POLL: assert property ((rd_stat && s.erase_op) |=>
		(hrdata[7] == 1'b0))
		else $error("poll bit not zero during erase");
	AST_WINDOW_FLAG: assert property ((rd_stat && s.st == fseq_pkg::S_WINDOW) |=> (hrdata[3] == 1'b0))
		else $error("window flag set while counting");
	AST_WINDOW_END: assert property ((s.st == fseq_pkg::S_WINDOW && !cmd_ev &&
		s.cnt == fseq_pkg::CNT_W'(fseq_pkg::WINDOW_CYC - 1)) |=>
		(s.st == fseq_pkg::S_SECT_ERS && s.arr.req && s.arr.op == fseq_pkg::OP_ERASE))
		else $error("erase did not start at window end");
	AST_WINDOW_ABORT: assert property ((s.st == fseq_pkg::S_WINDOW && cmd_ev &&
		wd != fseq_pkg::CODE_SECTOR && wd != fseq_pkg::CODE_SUSPEND) |=> (s.st == fseq_pkg::S_READ))
		else $error("stray command did not abort window");
	AST_SUSPEND_TIME: assert property ($rose(s.st == fseq_pkg::S_SUSPENDING) |->
		##[1:150] (s.st != fseq_pkg::S_SUSPENDING))
		else $error("suspend did not settle in time");
	AST_RESET_TIME: assert property ($rose(s.st == fseq_pkg::S_RST_WAIT) |->
		##[1:250] (s.st == fseq_pkg::S_READ && !s.err))
		else $error("reset did not reach read mode in time");
	AST_BULK_DEAF: assert property ((s.st == fseq_pkg::S_BULK_ERS && cmd_ev &&
		!flash_rsp.done && !flash_rsp.fail) |=> $stable(s.st) && !s.arr.req)
		else $error("command acted on during bulk erase");
	AST_BYPASS_REJECT: assert property ((s.st == fseq_pkg::S_BYP && cmd_ev &&
		wd != fseq_pkg::CODE_PROGRAM && wd != fseq_pkg::CODE_BYP_EXIT1) |=> (s.st == fseq_pkg::S_BYP))
		else $error("bypass accepted a foreign command");
	AST_BUSY_PIN: assert property ((s.arr.req && s.arr.op == fseq_pkg::OP_PROGRAM) |->
		!ready_busy_pin [*2])
		else $error("ready pin high while programming");
endmodule
`default_nettype wire

/* File: verification/flash_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire fseq_pkg::arr_req_t flash_cmd,
	input wire logic [9:0] dly,
	input wire logic fail_next,
	output var fseq_pkg::arr_rsp_t flash_rsp
);
	// one flat page for all sectors: erase and fill hit every byte
	logic [7:0] mem [0:4095];
	fseq_pkg::op_t cur;
	logic run;
	logic done_q;
	logic fail_q;
	logic [9:0] cnt;
	assign flash_rsp = {done_q, fail_q, mem[flash_cmd.raddr]};
	initial begin
		for (int i = 0; i < 4096; i++) mem[i] = 8'hff;
	end
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run <= 1'b0;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			cnt <= 10'h000;
			cur <= fseq_pkg::OP_NONE;
		end else begin
			done_q <= 1'b0;
			fail_q <= 1'b0;
			if (flash_cmd.req) begin
				case (flash_cmd.op)
					fseq_pkg::OP_PROGRAM, fseq_pkg::OP_FILL, fseq_pkg::OP_ERASE: begin
						cur <= flash_cmd.op;
						run <= 1'b1;
						cnt <= dly;
					end
					fseq_pkg::OP_SUSPEND: run <= 1'b0;
					fseq_pkg::OP_RESUME: run <= 1'b1;
					default: run <= 1'b0;
				endcase
			end else if (run && cnt > 10'h001) begin
				cnt <= cnt - 10'h001;
			end else if (run) begin
				run <= 1'b0;
				// a failure is only ever forced by the bench, never spontaneous
				if (fail_next) begin
					fail_q <= 1'b1;
				end else begin
					done_q <= 1'b1;
					if (cur == fseq_pkg::OP_PROGRAM)
						mem[flash_cmd.waddr] <= mem[flash_cmd.waddr] & flash_cmd.wdata;
					else
						for (int i = 0; i < 4096; i++)
							mem[i] <= (cur == fseq_pkg::OP_FILL) ? 8'h00 : 8'hff;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic hclk, hresetn, hsel, hwrite, fail_next;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [11:0] sector_protect;
	logic [9:0] dly;
	logic hreadyout, hresp, ready_busy_pin;
	logic [7:0] t;
	fseq_pkg::arr_req_t flash_cmd;
	fseq_pkg::arr_rsp_t flash_rsp;
	fseq_pkg::op_t ops[$];
	int n_fail, compares, n;
	flash_program_erase_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sector_protect(sector_protect), .flash_cmd(flash_cmd), .flash_rsp(flash_rsp),
		.ready_busy_pin(ready_busy_pin));
	flash_array_model array (.hclk(hclk), .hresetn(hresetn), .flash_cmd(flash_cmd),
		.dly(dly), .fail_next(fail_next), .flash_rsp(flash_rsp));
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) if (flash_cmd.req === 1'b1) ops.push_back(flash_cmd.op);
	task final_report;
		$display("checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task cmd(input logic [11:0] s, input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, fseq_pkg::OFF_CMD, {s, a, d});
	endtask
	task unlock(input logic [11:0] s);
		cmd(s, fseq_pkg::ADDR_UNLOCK1, fseq_pkg::CODE_UNLOCK1);
		cmd(s, fseq_pkg::ADDR_UNLOCK2, fseq_pkg::CODE_UNLOCK2);
	endtask
	task erase_pre(input logic [11:0] s);
		unlock(s);
		cmd(s, fseq_pkg::ADDR_UNLOCK1, fseq_pkg::CODE_ERASE);
		unlock(s);
	endtask
	task raddr(input logic [11:0] s, input logic [11:0] a);
		bus(1'b1, fseq_pkg::OFF_RADDR, {8'h00, s, a});
	endtask
	task stat_rd;
		bus(1'b0, fseq_pkg::OFF_RDATA, 32'h0);
	endtask
	task st(input fseq_pkg::state_t s);
		bus(1'b0, fseq_pkg::OFF_STAT, 32'h0);
		chk("state", {3'h0, s}, rd[7:0] & 8'h1f);
	endtask
	task wait_st(input fseq_pkg::state_t s);
		do bus(1'b0, fseq_pkg::OFF_STAT, 32'h0); while (rd[4:0] !== s);
	endtask
	initial begin
		// the watchdog allows several times the expected run length
		repeat (20000) @(posedge hclk);
		n_fail++;
		final_report;
	end
	initial begin
		{hsel, hwrite, fail_next, hresetn} = 4'h0;
		{haddr, hwdata, htrans} = 66'h0;
		hsize = 3'h2;
		sector_protect = 12'h008;
		dly = 10'd40;
		repeat (16) @(posedge hclk);
		chk("reset_pins", 8'h03, {6'h00, hreadyout, ready_busy_pin});
		chk("reset_req", 8'h00, {7'h00, flash_cmd.req});
		hresetn <= 1'b1;
		@(posedge hclk);
		raddr(12'h001, 12'h010);
		unlock(12'h001);
		cmd(12'h001, fseq_pkg::ADDR_UNLOCK1, fseq_pkg::CODE_PROGRAM);
		cmd(12'h001, 12'h010, 8'h5a);
		// the pin follows the state register, so look once it has settled
		@(negedge hclk);
		chk("busy_pin", 8'h00, {7'h00, ready_busy_pin});
		@(posedge hclk);
		stat_rd;
		chk("poll_inv", 8'h80, rd[7:0] & 8'ha0);
		t = rd[7:0];
		stat_rd;
		chk("toggle", t ^ 8'h40, rd[7:0] & 8'hc0);
		while (rd[7] !== 1'b0 || rd[5] !== 1'b0) stat_rd;
		stat_rd;
		chk("verify", 8'h5a, rd[7:0]);
		chk("ready_pin", 8'h01, {7'h00, ready_busy_pin});
		unlock(12'h001);
		cmd(12'h001, fseq_pkg::ADDR_UNLOCK1, fseq_pkg::CODE_PROGRAM);
		cmd(12'h001, 12'h010, 8'hff);
		stat_rd;
		chk("err_zero_one", 8'h20, rd[7:0] & 8'h20);
		chk("okay_resp", 8'h00, {7'h00, hresp});
		cmd(12'h001, 12'h000, fseq_pkg::CODE_RESET);
		st(fseq_pkg::S_RST_WAIT);
		repeat (fseq_pkg::RESET_CYC + 10) @(posedge hclk);
		st(fseq_pkg::S_READ);
		chk("err_clear", 8'h00, rd[7:0] & 8'h40);
		n = ops.size();
		unlock(12'h008);
		cmd(12'h008, fseq_pkg::ADDR_UNLOCK1, fseq_pkg::CODE_PROGRAM);
		cmd(12'h008, 12'h020, 8'h00);
		repeat (4) @(posedge hclk);
		chk("protect_ops", 8'(n), 8'(ops.size()));
		st(fseq_pkg::S_READ);
		unlock(12'h001);
		cmd(12'h001, fseq_pkg::ADDR_UNLOCK1, fseq_pkg::CODE_BYPASS);
		st(fseq_pkg::S_BYP);
		cmd(12'h001, 12'h000, fseq_pkg::CODE_PROGRAM);
		cmd(12'h001, 12'h011, 8'h3c);
		wait_st(fseq_pkg::S_BYP);
		raddr(12'h001, 12'h011);
		stat_rd;
		chk("bypass_prog", 8'h3c, rd[7:0]);
		cmd(12'h001, fseq_pkg::ADDR_UNLOCK1, fseq_pkg::CODE_ERASE);
		st(fseq_pkg::S_BYP);
		cmd(12'h001, 12'h123, fseq_pkg::CODE_BYP_EXIT1);
		cmd(12'h001, 12'h456, fseq_pkg::CODE_BYP_EXIT2);
		st(fseq_pkg::S_READ);
		chk("bypass_bit", 8'h00, rd[7:0] & 8'h20);
		unlock(12'h001);
		cmd(12'h001, fseq_pkg::ADDR_UNLOCK1, fseq_pkg::CODE_ERASE);
		cmd(12'h001, fseq_pkg::ADDR_UNLOCK1, fseq_pkg::CODE_UNLOCK1);
		cmd(12'h001, fseq_pkg::ADDR_UNLOCK2, 8'h77);
		st(fseq_pkg::S_READ);
		cmd(12'h002, 12'h000, fseq_pkg::CODE_SUSPEND);
		st(fseq_pkg::S_READ);
		erase_pre(12'h002);
		cmd(12'h002, 12'h000, fseq_pkg::CODE_SECTOR);
		st(fseq_pkg::S_WINDOW);
		cmd(12'h002, 12'h000, 8'h12);
		st(fseq_pkg::S_READ);
		n = ops.size();
		erase_pre(12'h001);
		cmd(12'h001, fseq_pkg::ADDR_UNLOCK1, fseq_pkg::CODE_BULK);
		cmd(12'h001, 12'h000, fseq_pkg::CODE_RESET);
		stat_rd;
		chk("bulk_poll", 8'h00, rd[7:0] & 8'h80);
		bus(1'b0, fseq_pkg::OFF_STAT, 32'h0);
		chk("bulk_busy", 8'h00, rd[7:0] & 8'h80);
		wait_st(fseq_pkg::S_BULK_ERS);
		cmd(12'h001, 12'h000, fseq_pkg::CODE_RESET);
		st(fseq_pkg::S_BULK_ERS);
		wait_st(fseq_pkg::S_READ);
		chk("fill_op", {5'h00, fseq_pkg::OP_FILL}, {5'h00, ops[n]});
		chk("erase_op", {5'h00, fseq_pkg::OP_ERASE}, {5'h00, ops[n+1]});
		stat_rd;
		chk("erased", 8'hff, rd[7:0]);
		dly <= 10'd300;
		raddr(12'h002, 12'h000);
		erase_pre(12'h002);
		cmd(12'h002, 12'h000, fseq_pkg::CODE_SECTOR);
		stat_rd;
		chk("window_flag0", 8'h00, rd[7:0] & 8'h88);
		repeat (600) @(posedge hclk);
		cmd(12'h004, 12'h000, fseq_pkg::CODE_SECTOR);
		repeat (700) @(posedge hclk);
		st(fseq_pkg::S_WINDOW);
		repeat (400) @(posedge hclk);
		stat_rd;
		chk("window_flag1", 8'h08, rd[7:0] & 8'h88);
		cmd(12'h002, 12'h000, fseq_pkg::CODE_SUSPEND);
		repeat (fseq_pkg::SUSP_CYC + 5) @(posedge hclk);
		stat_rd;
		t = rd[7:0];
		stat_rd;
		chk("susp_toggle", t, rd[7:0]);
		chk("susp_invalid", fseq_pkg::INVALID_BYTE, rd[7:0]);
		raddr(12'h001, 12'h011);
		stat_rd;
		chk("susp_other", 8'hff, rd[7:0]);
		unlock(12'h001);
		cmd(12'h001, fseq_pkg::ADDR_UNLOCK1, fseq_pkg::CODE_PROGRAM);
		cmd(12'h001, 12'h011, 8'h00);
		st(fseq_pkg::S_SUSPENDED);
		fail_next <= 1'b1;
		cmd(12'h002, 12'h000, fseq_pkg::CODE_RESUME);
		st(fseq_pkg::S_SECT_ERS);
		wait_st(fseq_pkg::S_ERROR);
		raddr(12'h002, 12'h000);
		stat_rd;
		chk("erase_err", 8'h20, rd[7:0] & 8'h20);
		fail_next <= 1'b0;
		cmd(12'h002, 12'h000, fseq_pkg::CODE_RESET);
		repeat (fseq_pkg::RESET_CYC + 10) @(posedge hclk);
		bus(1'b0, fseq_pkg::OFF_STAT, 32'h0);
		chk("after_reset", {3'h4, fseq_pkg::S_READ}, rd[7:0]);
		erase_pre(12'h002);
		cmd(12'h002, 12'h000, fseq_pkg::CODE_SECTOR);
		wait_st(fseq_pkg::S_SECT_ERS);
		cmd(12'h002, 12'h000, fseq_pkg::CODE_RESET);
		st(fseq_pkg::S_RST_WAIT);
		chk("abort_op", {5'h00, fseq_pkg::OP_ABORT}, {5'h00, ops[ops.size()-1]});
		repeat (fseq_pkg::RESET_CYC + 10) @(posedge hclk);
		st(fseq_pkg::S_READ);
		final_report;
	end
endmodule
`default_nettype wire
